// ==== inc/pin_change_regs.svh ====
`ifndef PIN_CHANGE_REGS_SVH
`define PIN_CHANGE_REGS_SVH

// Byte offsets of the register map
`define OFS_RISE_EN      8'h00
`define OFS_FALL_EN      8'h04
`define OFS_EDGE_STATUS  8'h08
`define OFS_INT_CTRL     8'h0C
`define OFS_IRQ_STATUS   8'h10
`define OFS_IRQ_CLEAR    8'h14
`define OFS_IRQ_ENABLE   8'h18

// Field positions in the interrupt control register
`define CTRL_SUMMARY_BIT 0
`define CTRL_MASTER_BIT  3

// Field positions in the event status register
`define EVT_EDGE_BIT     0
`define EVT_WAKE_BIT     1

// Reset values
`define RST_BYTE         8'h00
`define RST_EVT          2'h0

// Bus answers
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// ==== inc/pin_change_pkg.sv ====
package pin_change_pkg;

   // Port width
   typedef logic [7:0] port_t;

   // Block event flags
   typedef logic [1:0] evt_t;

   // Write channel progress
   typedef enum logic [1:0] {
      WR_IDLE,
      WR_RESP
   } wr_state_t;

endpackage

// ==== logic/pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pin_change_regs.svh"

// Three-stage synchroniser for the port pins
module pin_sync (
   // Clock and reset
   input  wire logic                        clk,
   input  wire logic                        rst_n,
   // Pins and their stable view
   input  wire pin_change_pkg::port_t       pins_raw,
   output var  pin_change_pkg::port_t       pins_stable
);

   pin_change_pkg::port_t s1_q;   // Metastable catch, read only by s2
   pin_change_pkg::port_t s2_q;   // Second stage
   pin_change_pkg::port_t s3_q;   // Third stage

   // Shift chain
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= `RST_BYTE;
         s2_q <= `RST_BYTE;
         s3_q <= `RST_BYTE;
      end else begin
         s1_q <= pins_raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Change accepted per bit once stages two and three agree
   genvar i;
   for (i = 0; i < 8; i++) begin : g_agree
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            pins_stable[i] <= 1'b0;
         end else if (s2_q[i] == s3_q[i]) begin
            pins_stable[i] <= s3_q[i];
         end
      end
   end

endmodule

`default_nettype wire

// ==== logic/edge_detect.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pin_change_regs.svh"

// Per-pin rising and falling edge detectors
module edge_detect (
   // Clock and reset
   input  wire logic                        clk,
   input  wire logic                        rst_n,
   // Sample and enables
   input  wire pin_change_pkg::port_t       sample,
   input  wire pin_change_pkg::port_t       rise_en,
   input  wire pin_change_pkg::port_t       fall_en,
   // One-cycle edge pulses
   output var  pin_change_pkg::port_t       edge_hit
);

   pin_change_pkg::port_t prev_q;   // Previous sample
   logic                  primed_q; // Blocks a false edge after reset

   // Remember previous sample
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_q   <= `RST_BYTE;
         primed_q <= 1'b0;
      end else begin
         prev_q   <= sample;
         primed_q <= 1'b1;
      end
   end

   // Compare per bit in each enabled direction
   genvar i;
   for (i = 0; i < 8; i++) begin : g_edge
      always_comb begin
         edge_hit[i] = primed_q &
                       ((rise_en[i] & sample[i] & ~prev_q[i]) |
                        (fall_en[i] & ~sample[i] & prev_q[i]));
      end
   end

endmodule

`default_nettype wire

// ==== logic/pin_change_irq.sv ====
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pin_change_regs.svh"

module pin_change_irq (
   // Clock and reset
   input  wire logic                  sys_clk,
   input  wire logic                  resetn,
   // Monitored port pins
   input  wire logic [7:0]            monitored_port,
   // Sleep state of the core
   input  wire logic                  core_sleeping,
   // Outputs to the core
   output logic                       pin_change_irq_req,
   output logic                       wake_req,
   output logic                       irq,
   // AXI4-Lite write address
   input  wire logic [7:0]            s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [7:0]            s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready
);

   // Reset release chain
   logic rst_a_q;                               // First stage
   logic rst_n;                                 // Released copy

   // Pin path
   pin_change_pkg::port_t pins_stable;          // Filtered pins
   pin_change_pkg::port_t edge_hit;             // Enabled edge pulses
   logic                  core_sleep_s1_q;      // Sleep sync stage one
   logic                  core_sleep_s2_q;      // Sleep sync stage two

   // Registers
   pin_change_pkg::port_t rise_detect_enable_reg; // Rising enables
   pin_change_pkg::port_t fall_detect_enable_reg; // Falling enables
   pin_change_pkg::port_t pin_edge_status_reg;    // Per-pin flags
   logic                  pin_change_master_enable;
   logic                  pin_change_summary_flag;
   pin_change_pkg::evt_t  evt_status_q;          // Sticky block events
   pin_change_pkg::evt_t  evt_enable_q;          // Event enables

   // Write channel holding
   pin_change_pkg::wr_state_t wr_state_q;
   logic        aw_held_q;                       // Address captured
   logic        w_held_q;                        // Data captured
   logic [7:0]  aw_addr_q;                       // Captured address
   logic [31:0] w_data_q;                        // Captured data
   logic        w_lane0_q;                       // Low byte strobe
   logic        wr_fire;                         // Perform write now

   // Status write decode
   logic                  status_wr;             // Status write this cycle
   pin_change_pkg::port_t status_next;           // Flag next value
   pin_change_pkg::evt_t  evt_set;               // Event set pulses
   pin_change_pkg::evt_t  evt_clr;               // Event clear pulses

   // Release reset through two flops
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rst_a_q <= 1'b0;
         rst_n   <= 1'b0;
      end else begin
         rst_a_q <= 1'b1;
         rst_n   <= rst_a_q;
      end
   end

   // Synchronise pins
   pin_sync u_sync (
      .clk         (sys_clk),
      .rst_n       (rst_n),
      .pins_raw    (monitored_port),
      .pins_stable (pins_stable)
   );

   // Detect enabled edges; both enables give either direction
   edge_detect u_edge (
      .clk      (sys_clk),
      .rst_n    (rst_n),
      .sample   (pins_stable),
      .rise_en  (rise_detect_enable_reg),
      .fall_en  (fall_detect_enable_reg),
      .edge_hit (edge_hit)
   );

   // Sleep level from the core domain boundary
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         core_sleep_s1_q <= 1'b0;
         core_sleep_s2_q <= 1'b0;
      end else begin
         core_sleep_s1_q <= core_sleeping;
         core_sleep_s2_q <= core_sleep_s1_q;
      end
   end

   // Write fires when both halves are held and no response pending
   assign wr_fire = aw_held_q & w_held_q & (wr_state_q == pin_change_pkg::WR_IDLE);

   // Capture write address and data in either order
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_held_q <= 1'b0;
         w_held_q  <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q  <= 32'h00000000;
         w_lane0_q <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_held_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_q  <= 1'b1;
            w_data_q  <= s_axi_wdata;
            w_lane0_q <= s_axi_wstrb[0];
         end else if (wr_fire) begin
            w_held_q <= 1'b0;
         end
      end
   end

   // Ready while the matching holding slot is empty and no response is pending
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         s_axi_awready <= ~aw_held_q & ~(s_axi_awvalid & s_axi_awready) &
                          (wr_state_q == pin_change_pkg::WR_IDLE);
         s_axi_wready  <= ~w_held_q & ~(s_axi_wvalid & s_axi_wready) &
                          (wr_state_q == pin_change_pkg::WR_IDLE);
      end
   end

   // Write response
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_state_q   <= pin_change_pkg::WR_IDLE;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `RESP_OKAY;
      end else begin
         case (wr_state_q)
            pin_change_pkg::WR_IDLE: begin
               if (wr_fire) begin
                  wr_state_q   <= pin_change_pkg::WR_RESP;
                  s_axi_bvalid <= 1'b1;
                  case (aw_addr_q)
                     // Mapped words answer OKAY, including OFS_IRQ_STATUS, which no register write decodes
                     `OFS_RISE_EN, `OFS_FALL_EN, `OFS_EDGE_STATUS,
                     `OFS_INT_CTRL, `OFS_IRQ_STATUS, `OFS_IRQ_CLEAR,
                     `OFS_IRQ_ENABLE: begin
                        s_axi_bresp <= `RESP_OKAY;
                     end
                     default: begin
                        s_axi_bresp <= `RESP_SLVERR;
                     end
                  endcase
               end
            end
            pin_change_pkg::WR_RESP: begin
               if (s_axi_bready) begin
                  wr_state_q   <= pin_change_pkg::WR_IDLE;
                  s_axi_bvalid <= 1'b0;
               end
            end
            default: begin
               wr_state_q   <= pin_change_pkg::WR_IDLE;
               s_axi_bvalid <= 1'b0;
            end
         endcase
      end
   end

   // Control registers written by software
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rise_detect_enable_reg   <= `RST_BYTE;
         fall_detect_enable_reg   <= `RST_BYTE;
         pin_change_master_enable <= 1'b0;
         evt_enable_q             <= `RST_EVT;
      end else if (wr_fire && w_lane0_q) begin
         case (aw_addr_q)
            `OFS_RISE_EN:    rise_detect_enable_reg <= w_data_q[7:0];
            `OFS_FALL_EN:    fall_detect_enable_reg <= w_data_q[7:0];
            `OFS_INT_CTRL:   pin_change_master_enable <= w_data_q[`CTRL_MASTER_BIT];
            `OFS_IRQ_ENABLE: evt_enable_q <= w_data_q[1:0];
            default: begin
               // Other offsets leave controls alone
            end
         endcase
      end
   end

   // Flag write: zero clears, one keeps
   always_comb begin
      status_wr   = wr_fire & w_lane0_q & (aw_addr_q == `OFS_EDGE_STATUS);
      status_next = pin_edge_status_reg;
      if (status_wr) begin
         status_next = pin_edge_status_reg & w_data_q[7:0];
      end
   end

   // Per-pin flags; a new edge wins over a clear, master ignored here
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_edge_status_reg <= `RST_BYTE;
      end else begin
         pin_edge_status_reg <= status_next | edge_hit;
      end
   end

   // Summary follows the flags each cycle
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_change_summary_flag <= 1'b0;
      end else begin
         pin_change_summary_flag <= |(status_next | edge_hit);
      end
   end

   // Interrupt and wake requests gated by the master enable
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_change_irq_req <= 1'b0;
         wake_req           <= 1'b0;
      end else begin
         pin_change_irq_req <= pin_change_master_enable & (|(status_next | edge_hit));
         wake_req           <= pin_change_master_enable & core_sleep_s2_q &
                               (|(status_next | edge_hit));
      end
   end

   // Sticky block events; set wins over clear
   always_comb begin
      evt_set = `RST_EVT;
      evt_set[`EVT_EDGE_BIT] = |edge_hit;
      evt_set[`EVT_WAKE_BIT] = pin_change_master_enable & core_sleep_s2_q & (|edge_hit);
      evt_clr = `RST_EVT;
      if (wr_fire && w_lane0_q && (aw_addr_q == `OFS_IRQ_CLEAR)) begin
         evt_clr = w_data_q[1:0];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         evt_status_q <= `RST_EVT;
      end else begin
         evt_status_q <= (evt_status_q & ~evt_clr) | evt_set;
      end
   end

   // Level interrupt from enabled events
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(((evt_status_q & ~evt_clr) | evt_set) & evt_enable_q);
      end
   end

   // Read channel: one cycle to answer, held until taken
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `RESP_OKAY;
      end else begin
         s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `RESP_OKAY;
            s_axi_rdata  <= 32'h00000000;
            case (s_axi_araddr)
               `OFS_RISE_EN:     s_axi_rdata[7:0] <= rise_detect_enable_reg;
               `OFS_FALL_EN:     s_axi_rdata[7:0] <= fall_detect_enable_reg;
               `OFS_EDGE_STATUS: s_axi_rdata[7:0] <= pin_edge_status_reg;
               `OFS_INT_CTRL: begin
                  s_axi_rdata[`CTRL_MASTER_BIT]  <= pin_change_master_enable;
                  s_axi_rdata[`CTRL_SUMMARY_BIT] <= pin_change_summary_flag;
               end
               `OFS_IRQ_STATUS:  s_axi_rdata[1:0] <= evt_status_q;
               `OFS_IRQ_CLEAR: begin
                  // Write-only, reads zero
               end
               `OFS_IRQ_ENABLE:  s_axi_rdata[1:0] <= evt_enable_q;
               default: begin
                  s_axi_rresp <= `RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule

`default_nettype wire

// ==== verification/pin_change_irq_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pin_change_regs.svh"
// Port-level checks of the pin change block
module pin_change_irq_asserts (
   // Clock and reset
   input wire logic        sys_clk,
   input wire logic        resetn,
   // Pins, core and requests
   input wire logic [7:0]  monitored_port,
   input wire logic        core_sleeping,
   input wire logic        pin_change_irq_req,
   input wire logic        wake_req,
   // Register bus
   input wire logic [7:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0]  s_axi_wstrb,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   logic       aw_q, w_q, mst_q; // Halves seen, shadow master enable
   logic [7:0] a_q, d_q;         // Captured address and data byte
   logic       s_q;              // Captured low strobe
   // Capture of each write half
   always_ff @(posedge sys_clk) begin
      if (s_axi_awvalid && s_axi_awready) a_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) d_q <= s_axi_wdata[7:0];
      if (s_axi_wvalid && s_axi_wready) s_q <= s_axi_wstrb[0];
   end
   // Shadow commits no later than the real register
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         aw_q  <= 1'b0;
         w_q   <= 1'b0;
         mst_q <= 1'b0;
      end else if (aw_q && w_q) begin
         aw_q <= 1'b0;
         w_q  <= 1'b0;
         if (a_q == `OFS_INT_CTRL && s_q) mst_q <= d_q[`CTRL_MASTER_BIT];
      end else begin
         if (s_axi_awvalid && s_axi_awready) aw_q <= 1'b1;
         if (s_axi_wvalid && s_axi_wready) w_q <= 1'b1;
      end
   end
   sequence master_off;
      (!mst_q) [*4];
   endsequence
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   AST_REQ_MASTER: assert property (master_off |-> !pin_change_irq_req)
      else $error("pin change request without master enable");
   AST_WAKE_MASTER: assert property (master_off |-> !wake_req)
      else $error("wake without master enable");
   AST_WAKE_SLEEP: assert property ((!core_sleeping) [*4] |-> !wake_req)
      else $error("wake while core awake");
   AST_QUIET_PORT: assert property (($stable(monitored_port) && mst_q) [*8]
      |=> !$rose(pin_change_irq_req)) else $error("request with quiet port");
   AST_WR_ANSWER: assert property (wr_taken |-> ##[1:3] s_axi_bvalid)
      else $error("write response late");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("write response dropped");
   AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("read data dropped");
   AST_B_ONCE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   AST_R_ONCE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read data repeated");
endmodule
bind pin_change_irq pin_change_irq_asserts pin_change_irq_asserts_inst (.*);
`default_nettype wire

// ==== verification/pin_source.sv ====
`timescale 1ns/1ps
`default_nettype none
// External signals on the port pins
module pin_source (
   input wire logic       sys_clk,
   input wire logic [7:0] level_req,
   input wire logic       slow,
   output var logic [7:0] pins = 8'h00
);
   logic [7:0] diff; // Bits still to move
   assign diff = pins ^ level_req;
   // Moves all bits at once, or the lowest differing bit per cycle when slow
   always @(posedge sys_clk) begin
      if (!slow) pins <= level_req;
      else pins <= pins ^ (diff & (~diff + 8'h01));
   end
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pin_change_regs.svh"
module tb_top;
   logic        sys_clk, resetn, core_sleeping, slow, irq;
   logic [7:0]  monitored_port, level_req, s_axi_awaddr, s_axi_araddr;
   logic        pin_change_irq_req, wake_req, s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   int          errors, comparisons;
   pin_change_irq pin_change_irq_inst (.*);
   pin_source pin_source_inst (.sys_clk, .level_req, .slow, .pins(monitored_port));
   always #5 sys_clk = ~sys_clk;
   task automatic results();
      if (errors == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One bus transfer; response ready is held high from the request on
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er, output logic [31:0] q);
      int   n;
      logic done, v;
      done = 1'b0;
      n = 0;
      q = 32'h0;
      @(posedge sys_clk);
      if (w) begin
         s_axi_awaddr <= a;
         s_axi_awvalid <= 1'b1;
         s_axi_wdata <= d;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
      end else begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
      end
      while (!done && n < 50) begin
         @(posedge sys_clk);
         n++;
         v = w ? s_axi_bvalid : s_axi_rvalid;
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         if (v === 1'b1) begin
            q = s_axi_rdata;
            chk("resp", 32'(er), 32'(w ? s_axi_bresp : s_axi_rresp));
            s_axi_bready <= 1'b0;
            s_axi_rready <= 1'b0;
            done = 1'b1;
         end
      end
      if (!done) begin
         chk("bus wait", 32'h1, 32'h0);
         results();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, `RESP_OKAY, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, `RESP_OKAY, q);
      chk($sformatf("reg %h", a), e, q);
   endtask
   task automatic pin(input logic [7:0] v, input logic s);
      @(posedge sys_clk);
      level_req <= v;
      slow <= s;
      repeat (20) @(posedge sys_clk);
   endtask
   // Reset values, unmapped place, read-only summary
   task automatic t_map();
      logic [31:0] q;
      for (int i = 0; i < 7; i++) begin
         rd(8'(4 * i), 32'h0);
      end
      bus(1'b0, 8'h1C, 32'h0, `RESP_SLVERR, q);
      bus(1'b1, 8'h1C, 32'hFF, `RESP_SLVERR, q);
      wr(`OFS_INT_CTRL, 32'h01);
      rd(`OFS_INT_CTRL, 32'h0);
      s_axi_wstrb <= 4'h0;
      wr(`OFS_RISE_EN, 32'hFF);
      s_axi_wstrb <= 4'hF;
      rd(`OFS_RISE_EN, 32'h0);
   endtask
   // Edge landing on a flag clear keeps the flag: a lost edge shows as a long gap
   task automatic t_race();
      int   run, worst;
      logic go;
      run = 0;
      worst = 0;
      go = 1'b1;
      wr(`OFS_RISE_EN, 32'h01);
      wr(`OFS_FALL_EN, 32'h01);
      wr(`OFS_INT_CTRL, 32'h08);
      fork
         while (go) begin
            repeat (2) @(posedge sys_clk);
            level_req[0] <= ~level_req[0];
         end
         begin
            repeat (12) @(posedge sys_clk);
            for (int i = 0; i < 4; i++) begin
               wr(`OFS_EDGE_STATUS, 32'h0);
               repeat (i) @(posedge sys_clk);
            end
            go = 1'b0;
         end
         begin
            repeat (12) @(posedge sys_clk);
            while (go) begin
               @(posedge sys_clk);
               if (pin_change_irq_req === 1'b1) run = 0;
               else run++;
               if (run > worst) worst = run;
            end
         end
      join
      wr(`OFS_INT_CTRL, 32'h0);
      chk("flag gap", 32'h1, 32'(worst));
   endtask
   // Edge directions, flags and master enable
   task automatic t_edges();
      wr(`OFS_RISE_EN, 32'hFFFFFF0F);
      wr(`OFS_FALL_EN, 32'h3C);
      rd(`OFS_RISE_EN, 32'h0F);
      pin(8'hFF, 1'b1);
      rd(`OFS_EDGE_STATUS, 32'h0F);
      rd(`OFS_INT_CTRL, 32'h01);
      chk("irq_req", 32'h0, 32'(pin_change_irq_req));
      wr(`OFS_EDGE_STATUS, 32'h0);
      pin(8'h00, 1'b0);
      rd(`OFS_EDGE_STATUS, 32'h3C);
      wr(`OFS_INT_CTRL, 32'h08);
      repeat (12) @(posedge sys_clk);
      chk("irq_req", 32'h1, 32'(pin_change_irq_req));
      rd(`OFS_INT_CTRL, 32'h09);
      wr(`OFS_EDGE_STATUS, 32'hFB);
      rd(`OFS_EDGE_STATUS, 32'h38);
      wr(`OFS_EDGE_STATUS, 32'h0);
      repeat (12) @(posedge sys_clk);
      chk("irq_req", 32'h0, 32'(pin_change_irq_req));
      rd(`OFS_INT_CTRL, 32'h08);
   endtask
   // Interrupt raised, masked and cleared
   task automatic t_events();
      wr(`OFS_IRQ_CLEAR, 32'h03);
      rd(`OFS_IRQ_STATUS, 32'h0);
      wr(`OFS_IRQ_ENABLE, 32'h01);
      pin(8'h01, 1'b0);
      rd(`OFS_IRQ_STATUS, 32'h01);
      chk("irq", 32'h1, 32'(irq));
      wr(`OFS_IRQ_ENABLE, 32'h0);
      repeat (4) @(posedge sys_clk);
      chk("irq", 32'h0, 32'(irq));
      wr(`OFS_IRQ_ENABLE, 32'h01);
      wr(`OFS_EDGE_STATUS, 32'h0);
      wr(`OFS_IRQ_CLEAR, 32'h01);
      repeat (4) @(posedge sys_clk);
      chk("irq", 32'h0, 32'(irq));
   endtask
   // Wake from sleep with and without master enable
   task automatic t_sleep();
      @(posedge sys_clk);
      core_sleeping <= 1'b1;
      pin(8'h05, 1'b0);
      chk("wake_req", 32'h1, 32'(wake_req));
      rd(`OFS_EDGE_STATUS, 32'h04);
      rd(`OFS_IRQ_STATUS, 32'h03);
      wr(`OFS_INT_CTRL, 32'h0);
      wr(`OFS_EDGE_STATUS, 32'h0);
      pin(8'h01, 1'b0);
      chk("wake_req", 32'h0, 32'(wake_req));
      chk("irq_req", 32'h0, 32'(pin_change_irq_req));
      rd(`OFS_EDGE_STATUS, 32'h04);
      @(posedge sys_clk);
      core_sleeping <= 1'b0;
   endtask
   initial begin
      sys_clk = 1'b0;
      resetn = 1'b0;
      core_sleeping = 1'b0;
      slow = 1'b0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      {s_axi_awaddr, s_axi_araddr, level_req} = 24'h0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      errors = 0;
      comparisons = 0;
      repeat (5) @(posedge sys_clk);
      resetn <= 1'b1;
      t_map();
      t_edges();
      t_events();
      t_sleep();
      t_race();
      results();
   end
endmodule
`default_nettype wire
